// file: pkg/out_sync_pkg.sv
// Package: constants and carrier types for the output sync and auto-mute block
package out_sync_pkg;
  // Counts
  localparam int NUM_PLL = 3;
  localparam int NUM_OUT = 8;
  localparam int MUX_W = 2;
  localparam int DIV_W = 12;
  // Register map (word addresses on the plain port)
  localparam logic [7:0] ADDR_GLOBAL = 8'h15;     // Holds software sync bit
  localparam logic [7:0] ADDR_PLL_CTRL = 8'h20;   // Per-PLL mute and sync enables
  localparam logic [7:0] ADDR_PLL_STATUS = 8'h21; // Lock status, read only
  localparam logic [7:0] ADDR_OUT_BASE = 8'h30;   // One word per output
  localparam logic [7:0] ADDR_OUT_STATE = 8'h40;  // Mute/hold state, read only
  localparam logic [7:0] ADDR_PIN_CFG = 8'h41;    // Pin function and polarity
  // Global register fields
  localparam int SW_SYNC_BIT = 6;
  localparam int SYNC_EN_BIT = 0;
  // Per-PLL control fields (4 bits per PLL)
  localparam int PLL_FIELD_W = 4;
  localparam int MUTE_APLL_BIT = 0;
  localparam int MUTE_DPLL_BIT = 1;
  localparam int MUTE_PHASE_BIT = 2;
  localparam int POST_SYNC_BIT = 3;
  // Per-output fields
  localparam int OUT_DIV_LSB = 0;
  localparam int OUT_MUX_LSB = 12;
  localparam int OUT_MUTE_EN_BIT = 14;
  localparam int OUT_SYNC_EN_BIT = 15;
  localparam int OUT_SR_SYNC_BIT = 16;
  localparam int OUT_SR_PRESENT_BIT = 17;
  // Pin configuration fields
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_MODE_W = 6;
  localparam int PIN_POL_BIT = 6;
  localparam logic [5:0] PIN_MODE_SYNC = 6'd31;
  // Reset values
  localparam logic [31:0] GLOBAL_RST = 32'h0000_0001;
  localparam logic [31:0] PLL_CTRL_RST = 32'h0000_0111;
  localparam logic [31:0] OUT_CFG_RST = 32'h0000_4001;
  localparam logic [31:0] PIN_CFG_RST = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic analogLock;
    logic freqLock;
    logic phaseLock;
  } pll_lock_t;
endpackage

// file: rtl/output_sync_and_automute.sv
// Design: output dividers with SYNC hold/release and auto-mute on loss of lock
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// R1: Mute-enabled output gated while source invalid
// R2: Invalid source from selected PLL lock conditions
// R3: Mute enable zero never mutes output
// R4: Outputs start together once analog lock returns
// R5: Group dividers leave reset same PLL cycle
// R6: Software sets all three group enables
// R7: SYNC from pin mode 31 or bit
// R8: Asserted SYNC mutes and holds enabled dividers
// R9: SYNC release starts outputs phase aligned
// R10: Held outputs stay low during SYNC
// R11: Sync-disabled channels are never held by SYNC
// R12: Unselected post-dividers keep running through SYNC
// R13: Outputs from held post-divider count invalid
// R14: Divide-by-one outputs never held by SYNC
// R15: Sync pin synchronised before use
module output_sync_and_automute
  import out_sync_pkg::*;
#(
  parameter int NOUT = NUM_OUT
) (
  input wire logic sysClk,                  // Single 50 MHz clock
  input wire logic rst,                     // Synchronous reset, active high
  input wire reg_req_t regReq,              // Register port request
  output logic [31:0] regRdata,             // Read data, cycle after strobe
  input wire pll_lock_t [NUM_PLL-1:0] pllLock, // Lock status per PLL
  input wire logic [NUM_PLL-1:0] pllTick,   // One-cycle enable per PLL output clock
  input wire logic syncPin,                 // External sync pin level
  output logic [NOUT-1:0] clkOut,           // Output clock levels
  output logic [NOUT-1:0] outMuted,         // Output held or muted
  output logic [NUM_PLL-1:0] postDivHeld    // Post-divider held by SYNC
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] globalCfg;
    logic [31:0] pllCtrl;
    logic [31:0] pinCfg;
    logic [NOUT-1:0][31:0] outCfg;
    logic [NOUT-1:0][DIV_W-1:0] divCnt;
    logic [NOUT-1:0] clkLvl;
    logic [NOUT-1:0] held;
    logic [NOUT-1:0] muted;
    logic [NUM_PLL-1:0] pinMeta;
    logic [NUM_PLL-1:0] pinSync;
    logic [NUM_PLL-1:0] syncActive;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Lock judgement for one PLL against its mute control bits
  function automatic logic srcInvalid(input pll_lock_t lk, input logic [3:0] ctl);
    srcInvalid = (ctl[MUTE_APLL_BIT] && !lk.analogLock)
      || (ctl[MUTE_DPLL_BIT] && !lk.freqLock)
      || (ctl[MUTE_PHASE_BIT] && !lk.phaseLock); // see R2
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Sync request combines the bit and the pin, pin level is qualified by mode and polarity.
  // Release is decided in each PLL domain on its own tick so every divider of a group
  // leaves reset on the same PLL cycle.
  always_comb begin
    logic pinAsserted;
    logic [MUX_W-1:0] sel;
    logic [DIV_W-1:0] divVal;
    logic [3:0] ctl;
    logic holdNow;
    logic bad;
    pinAsserted = 1'b0;
    sel = '0;
    divVal = '0;
    ctl = '0;
    holdNow = 1'b0;
    bad = 1'b0;
    st_nxt = st_r;

    // Register writes
    if (regReq.wr) begin
      unique case (regReq.addr)
        ADDR_GLOBAL: st_nxt.globalCfg = regReq.wdata;
        ADDR_PLL_CTRL: st_nxt.pllCtrl = regReq.wdata;
        ADDR_PIN_CFG: st_nxt.pinCfg = regReq.wdata;
        default: begin
          for (int i = 0; i < NOUT; i++) begin
            if (regReq.addr == ADDR_OUT_BASE + 8'(i)) begin
              st_nxt.outCfg[i] = regReq.wdata;
            end
          end
        end
      endcase
    end

    // Register reads, unmapped addresses answer zero
    st_nxt.rdata = '0;
    if (regReq.rd) begin
      unique case (regReq.addr)
        ADDR_GLOBAL: st_nxt.rdata = st_r.globalCfg;
        ADDR_PLL_CTRL: st_nxt.rdata = st_r.pllCtrl;
        ADDR_PIN_CFG: st_nxt.rdata = st_r.pinCfg;
        ADDR_PLL_STATUS: begin
          for (int p = 0; p < NUM_PLL; p++) begin
            st_nxt.rdata[p*PLL_FIELD_W +: 3] = {pllLock[p].phaseLock,
              pllLock[p].freqLock, pllLock[p].analogLock};
            st_nxt.rdata[p*PLL_FIELD_W + 3] = st_r.syncActive[p];
          end
        end
        ADDR_OUT_STATE: begin
          st_nxt.rdata[15:0] = 16'(st_r.muted);
          st_nxt.rdata[31:16] = 16'(st_r.held);
        end
        default: begin
          for (int i = 0; i < NOUT; i++) begin
            if (regReq.addr == ADDR_OUT_BASE + 8'(i)) begin
              st_nxt.rdata = st_r.outCfg[i];
            end
          end
        end
      endcase
    end

    // Pin qualified by mode 31, polarity 1 makes low the active level
    pinAsserted = (st_r.pinCfg[PIN_MODE_LSB +: PIN_MODE_W] == PIN_MODE_SYNC)
      && (syncPin ^ st_r.pinCfg[PIN_POL_BIT]); // see R7 see R8

    // Two-stage synchroniser per PLL domain, advanced on that PLL's tick
    for (int p = 0; p < NUM_PLL; p++) begin
      if (pllTick[p]) begin
        st_nxt.pinMeta[p] = pinAsserted;   // see R15
        st_nxt.pinSync[p] = st_r.pinMeta[p];
        // Post-divider held only if its sync enable and the global enable are on
        st_nxt.syncActive[p] = st_r.globalCfg[SYNC_EN_BIT]
          && st_r.pllCtrl[p*PLL_FIELD_W + POST_SYNC_BIT]
          && (st_r.pinSync[p] || st_r.globalCfg[SW_SYNC_BIT]); // see R6 see R12
      end
    end

    // Per-output divider, hold and mute
    for (int i = 0; i < NOUT; i++) begin
      sel = st_r.outCfg[i][OUT_MUX_LSB +: MUX_W];
      divVal = st_r.outCfg[i][OUT_DIV_LSB +: DIV_W];
      if (32'(sel) >= NUM_PLL) begin
        sel = '0;
      end
      ctl = st_r.pllCtrl[32'(sel)*PLL_FIELD_W +: PLL_FIELD_W];
      // A divider with a cascaded sysref stage needs both enables
      holdNow = st_r.syncActive[sel] && st_r.outCfg[i][OUT_SYNC_EN_BIT]
        && (!st_r.outCfg[i][OUT_SR_PRESENT_BIT] || st_r.outCfg[i][OUT_SR_SYNC_BIT])
        && (divVal > 12'h001); // see R8 see R11 see R14
      // Source unlocked, or its post-divider held, makes it invalid
      bad = srcInvalid(pllLock[sel], ctl) || st_r.syncActive[sel]; // see R13
      st_nxt.held[i] = holdNow;
      st_nxt.muted[i] = st_r.outCfg[i][OUT_MUTE_EN_BIT] && bad; // see R1 see R3
      if (pllTick[sel]) begin
        if (holdNow || st_nxt.muted[i]) begin
          // Reset count and force low, release restarts from a known phase
          st_nxt.divCnt[i] = '0;             // see R5 see R9 see R4
          st_nxt.clkLvl[i] = 1'b0;           // see R10
        end else if (divVal <= 12'h001) begin
          st_nxt.clkLvl[i] = ~st_r.clkLvl[i];
        end else if (st_r.divCnt[i] == (divVal >> 1) - 12'h001
            || st_r.divCnt[i] == divVal - 12'h001) begin
          st_nxt.clkLvl[i] = ~st_r.clkLvl[i];
          st_nxt.divCnt[i] = (st_r.divCnt[i] == divVal - 12'h001) ? '0
            : st_r.divCnt[i] + 12'h001;
        end else begin
          st_nxt.divCnt[i] = st_r.divCnt[i] + 12'h001;
        end
      end
    end

    if (rst) begin
      st_nxt = '0;
      st_nxt.globalCfg = GLOBAL_RST;
      st_nxt.pllCtrl = PLL_CTRL_RST;
      st_nxt.pinCfg = PIN_CFG_RST;
      for (int i = 0; i < NOUT; i++) begin
        st_nxt.outCfg[i] = OUT_CFG_RST;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge sysClk) begin
    st_r <= st_nxt;
  end

  // Outputs are built from flip-flops by simple gating; a muted or held output is gated low at once,
  // so a held channel without mute enable cannot stay high until its next PLL tick
  assign regRdata = st_r.rdata;
  assign clkOut = st_r.clkLvl & ~st_r.muted & ~st_r.held; // see R10
  assign outMuted = st_r.muted | st_r.held;
  assign postDivHeld = st_r.syncActive;

endmodule

`default_nettype wire

// file: testbench/output_sync_props.sv
// Port checks for output sync and auto-mute
`timescale 1ns/1ns
`default_nettype none
module output_sync_props
  import out_sync_pkg::*;
#(
  parameter int NOUT = NUM_OUT
) (
  input wire logic sysClk, // Clock
  input wire logic rst, // Reset
  input wire reg_req_t regReq, // Bus request
  input wire logic [31:0] regRdata, // Read data
  input wire pll_lock_t [NUM_PLL-1:0] pllLock, // Locks
  input wire logic [NUM_PLL-1:0] pllTick, // PLL edges
  input wire logic syncPin, // Pin
  input wire logic [NOUT-1:0] clkOut, // Clocks
  input wire logic [NOUT-1:0] outMuted, // Mutes
  input wire logic [NUM_PLL-1:0] postDivHeld // Holds
);
  // Hold changes may lag their PLL edge by one register stage
  default clocking @(posedge sysClk); endclocking
  default disable iff (rst);
  property p_rst; $fell(rst) |-> clkOut == '0 && outMuted == '0 && postDivHeld == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_low; (clkOut & outMuted) == '0; endproperty
  a_low: assert property (p_low) else $error("muted output high");
  property p_idle; !$past(regReq.rd) |-> regRdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("stray read data");
  property p_unmap; $past(regReq.rd) && $past(regReq.addr) == 8'hff |-> regRdata == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_hold; (postDivHeld & ~$past(postDivHeld) & ~($past(pllTick) | $past(pllTick, 2))) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("hold off tick");
  property p_rel; ($past(postDivHeld) & ~postDivHeld & ~($past(pllTick) | $past(pllTick, 2))) == '0;
  endproperty
  a_rel: assert property (p_rel) else $error("release off tick");
  property p_cause; !$past(|pllTick) && $stable(outMuted) |-> $stable(clkOut); endproperty
  a_cause: assert property (p_cause) else $error("output moved alone");
  property p_state; $past(regReq.rd) && $past(regReq.addr) == ADDR_OUT_STATE
    |-> (regRdata[NOUT-1:0] | regRdata[16 +: NOUT]) == $past(outMuted); endproperty
  a_state: assert property (p_state) else $error("state read");
endmodule
bind output_sync_and_automute output_sync_props #(.NOUT(NOUT)) i_output_sync_props (.sysClk,
  .rst, .regReq, .regRdata, .pllLock, .pllTick, .syncPin, .clkOut, .outMuted, .postDivHeld);
`default_nettype wire

// file: testbench/sync_pin_drv.sv
// External sync pin driver
`timescale 1ns/1ns
`default_nettype none
module sync_pin_drv (
  input wire logic sysClk, // Clock
  input wire logic syncReq, // Host request
  input wire logic polInv, // High: active low pin
  output logic syncPin // Pin level
);
  initial syncPin = 1'b0;
  // Moves just after an edge, as a board driver would
  always @(posedge sysClk) syncPin <= syncReq ^ polInv;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Bench for output sync and auto-mute
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin checksDone++; if ((a)!==(b)) begin errorCnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_top;
  import out_sync_pkg::*;
  logic sysClk = 0, rst = 1, syncReq = 0, polInv = 0, syncPin, al;
  reg_req_t regReq = '0;
  pll_lock_t [NUM_PLL-1:0] pllLock = '1;
  logic [NUM_PLL-1:0] pllTick = '0, postDivHeld;
  logic [31:0] regRdata;
  logic [NUM_OUT-1:0] clkOut, outMuted, p;
  integer seed = 34, errorCnt = 0, checksDone = 0, n, t0, t3, t5;
  int cfg[$] = '{32'hc002, 32'hc002, 32'hc002, 32'h8001, 32'h4002, 32'h5002}; // Output words
  always #10 sysClk = ~sysClk;
  // Random PLL edges keep every divider busy
  always @(posedge sysClk) pllTick <= 3'($random(seed));
  output_sync_and_automute i_output_sync_and_automute (.sysClk, .rst, .regReq, .regRdata,
    .pllLock, .pllTick, .syncPin, .clkOut, .outMuted, .postDivHeld);
  sync_pin_drv i_sync_pin_drv (.sysClk, .syncReq, .polInv, .syncPin);
  task testDone();
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sysClk) regReq <= '{a, d, 1'b1, 1'b0};
    @(posedge sysClk) regReq.wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sysClk) regReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sysClk) regReq.rd <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask
  // Bounded wait on the first output's mute or the first PLL's hold
  task waitSig(input logic mut, input logic v);
    for (int i = 0; i < 60; i++) begin
      @(posedge sysClk) #1;
      if ((mut ? outMuted[0] : postDivHeld[0]) === v) return;
    end
    errorCnt++;
    testDone();
  endtask
  // Edge counts on a group, a bypass and a foreign output
  task watch();
    p = clkOut;
    t0 = 0;
    t3 = 0;
    t5 = 0;
    al = 1;
    repeat (24) begin
      @(posedge sysClk) #1;
      t0 += clkOut[0] ^ p[0];
      t3 += clkOut[3] ^ p[3];
      t5 += clkOut[5] ^ p[5];
      al &= clkOut[2:0] == 3'b000 || clkOut[2:0] == 3'b111;
      p = clkOut;
    end
  endtask
  initial begin
    repeat (12) @(posedge sysClk);
    rst <= 1'b0;
    rd(ADDR_GLOBAL, GLOBAL_RST);
    rd(ADDR_PLL_CTRL, PLL_CTRL_RST);
    rd(ADDR_OUT_BASE, OUT_CFG_RST);
    rd(ADDR_PIN_CFG, PIN_CFG_RST);
    rd(8'hff, 32'h0);
    foreach (cfg[i]) wr(ADDR_OUT_BASE + 8'(i), cfg[i]);
    foreach (cfg[i]) rd(ADDR_OUT_BASE + 8'(i), cfg[i]);
    $display("test 1 end");
    // Each lock condition mutes only when its control bit is set
    for (n = 0; n < 6; n++) begin
      wr(ADDR_PLL_CTRL, 32'h110 | ((n % 2) << (n / 2)));
      pllLock[0] <= 3'b111 ^ (3'b100 >> (n / 2));
      waitSig(1, 1'(n % 2));
      repeat (4) @(posedge sysClk);
      #1 `CHK(outMuted[0], 1'(n % 2))
      `CHK(outMuted[3], 1'b0)
      @(posedge sysClk) pllLock[0] <= '1;
      waitSig(1, 1'b0);
    end
    $display("test 2 end");
    wr(ADDR_PLL_CTRL, 32'h119);
    wr(ADDR_GLOBAL, 32'h41);
    waitSig(0, 1'b1);
    rd(ADDR_OUT_STATE, 32'h0007_00d7);
    rd(ADDR_PLL_STATUS, 32'h0000_077f);
    watch();
    `CHK(outMuted[2:0], 3'b111)
    `CHK(t0, 0)
    `CHK(t3 > 0, 1'b1)
    `CHK(t5 > 0 && outMuted[5] === 1'b0, 1'b1)
    wr(ADDR_GLOBAL, 32'h01);
    waitSig(0, 1'b0);
    watch();
    `CHK(al && t0 > 0, 1'b1)
    $display("test 3 end");
    // Pin request at both polarities; polarity set while the pin is not yet a sync input
    for (n = 0; n < 2; n++) begin
      wr(ADDR_PIN_CFG, 32'(n) << 6);
      polInv <= n[0];
      wr(ADDR_PIN_CFG, (32'(n) << 6) | 32'h1f);
      syncReq <= 1'b1;
      waitSig(0, 1'b1);
      @(posedge sysClk) syncReq <= 1'b0;
      #1 `CHK(outMuted[2:0], 3'b111)
      waitSig(0, 1'b0);
    end
    $display("test 4 end");
    testDone();
  end
endmodule
`default_nettype wire
